// *** common/bcc_pkg.sv ***
// package: opcodes, flag positions, cycle counts for the branch/call unit
// Function
// - relative branch two bytes, 3 taken, 2 not
// - signed less when V xor N
// - signed less-equal when (V xor N) or Z
// - unsigned lower-same when C or Z
// - accumulator jump loads pc, bank kept, 2 cycles
// - far indirect jump: pc, bank from offset 2
// - immediate far jump, 3 cycles, split address
// - near indirect call pushes word, reads target
// - near immediate and vector call push word, 5
// - far indirect call pushes long, reads long
// - immediate far call pushes long, 7 cycles
// - far memory call 8 plus correction cycles
package bcc_pkg;
  typedef enum logic [4:0] {
    bcc_op_nop,
    bcc_op_branch_if_zero_set,
    bcc_op_branch_if_zero_clear,
    bcc_op_branch_if_carry_set,
    bcc_op_branch_if_carry_clear,
    bcc_op_branch_if_negative,
    bcc_op_branch_if_positive,
    bcc_op_branch_if_overflow,
    bcc_op_branch_if_no_overflow,
    bcc_op_branch_if_sticky,
    bcc_op_branch_if_not_sticky,
    bcc_op_branch_signed_less,
    bcc_op_branch_signed_greater_equal,
    bcc_op_branch_signed_less_equal,
    bcc_op_branch_signed_greater,
    bcc_op_branch_unsigned_lower_same,
    bcc_op_branch_unsigned_higher,
    bcc_op_branch_always,
    bcc_op_near_jump_acc,
    bcc_op_near_jump_imm,
    bcc_op_near_jump_reg,
    bcc_op_near_jump_mem,
    bcc_op_far_jump_reg,
    bcc_op_far_jump_mem,
    bcc_op_far_jump_imm,
    bcc_op_call_reg,
    bcc_op_call_mem,
    bcc_op_call_imm,
    bcc_op_vector_subroutine_invoke,
    bcc_op_far_subroutine_invoke_reg,
    bcc_op_far_subroutine_invoke_mem,
    bcc_op_far_subroutine_invoke_imm
  } bcc_op_e;

  // flag vector bit positions {t, n, z, v, c}
  localparam int BCC_FLAG_C = 0;
  localparam int BCC_FLAG_V = 1;
  localparam int BCC_FLAG_Z = 2;
  localparam int BCC_FLAG_N = 3;
  localparam int BCC_FLAG_T = 4;

  localparam int BCC_PC_LSB   = 0;
  localparam int BCC_PC_MSB   = 15;
  localparam int BCC_BANK_LSB = 16;
  localparam int BCC_BANK_MSB = 23;

  localparam logic [15:0] BCC_BANK_OFFSET = 16'h0002;
  localparam logic [15:0] BCC_VEC_BASE    = 16'hffc0;
  localparam logic [3:0]  BCC_VEC_SHIFT   = 4'h1;

  localparam logic [4:0] BCC_CYC_BR_TAKEN = 5'h03;
  localparam logic [4:0] BCC_CYC_BR_NOT   = 5'h02;
  localparam logic [4:0] BCC_CYC_JMP_ACC  = 5'h02;
  localparam logic [4:0] BCC_CYC_JMP_IMM  = 5'h02;
  localparam logic [4:0] BCC_CYC_JMP_REG  = 5'h03;
  localparam logic [4:0] BCC_CYC_JMP_MEM  = 5'h04;
  localparam logic [4:0] BCC_CYC_FJMP_REG = 5'h03;
  localparam logic [4:0] BCC_CYC_FJMP_MEM = 5'h04;
  localparam logic [4:0] BCC_CYC_FJMP_IMM = 5'h03;
  localparam logic [4:0] BCC_CYC_CALL_REG = 5'h04;
  localparam logic [4:0] BCC_CYC_CALL_MEM = 5'h05;
  localparam logic [4:0] BCC_CYC_CALL_IMM = 5'h05;
  localparam logic [4:0] BCC_CYC_VECTOR_SUBROUTINE_INVOKE    = 5'h05;
  localparam logic [4:0] BCC_CYC_FCALL_RG = 5'h07;
  localparam logic [4:0] BCC_CYC_FCALL_MM = 5'h08;
  localparam logic [4:0] BCC_CYC_FCALL_IM = 5'h07;
  localparam logic [4:0] BCC_CYC_ONE      = 5'h01;

  localparam logic [2:0] BCC_LEN_BRANCH = 3'h2;
  localparam logic [2:0] BCC_LEN_ONE    = 3'h1;
  localparam logic [2:0] BCC_LEN_TWO    = 3'h2;
  localparam logic [2:0] BCC_LEN_THREE  = 3'h3;
  localparam logic [2:0] BCC_LEN_FOUR   = 3'h4;
endpackage

// *** design/bcc_cond_eval.sv ***
// condition evaluator for relative branches
`timescale 1ns/100ps
`default_nettype none
module bcc_cond_eval
  import bcc_pkg::*;
(
  input  wire logic          mclk,   // machine clock
  input  wire logic          rst_n,  // synchronised reset
  input  wire bcc_op_e       op,     // opcode
  input  wire logic [4:0]    flags,  // {t,n,z,v,c}
  output logic               take    // registered branch decision
);
  logic c, v, z, n, t, sv;
  logic next_take;

  always_comb begin
    c = flags[BCC_FLAG_C];
    v = flags[BCC_FLAG_V];
    z = flags[BCC_FLAG_Z];
    n = flags[BCC_FLAG_N];
    t = flags[BCC_FLAG_T];
    sv = v ^ n;
    case (op)
      bcc_op_branch_if_zero_set:          next_take = z;
      bcc_op_branch_if_zero_clear:        next_take = !z;
      bcc_op_branch_if_carry_set:         next_take = c;
      bcc_op_branch_if_carry_clear:       next_take = !c;
      bcc_op_branch_if_negative:          next_take = n;
      bcc_op_branch_if_positive:          next_take = !n;
      bcc_op_branch_if_overflow:          next_take = v;
      bcc_op_branch_if_no_overflow:       next_take = !v;
      bcc_op_branch_if_sticky:            next_take = t;
      bcc_op_branch_if_not_sticky:        next_take = !t;
      bcc_op_branch_signed_less:          next_take = sv;
      bcc_op_branch_signed_greater_equal: next_take = !sv;
      bcc_op_branch_signed_less_equal:    next_take = sv | z;
      bcc_op_branch_signed_greater:       next_take = !(sv | z);
      bcc_op_branch_unsigned_lower_same:  next_take = c | z;
      bcc_op_branch_unsigned_higher:      next_take = !(c | z);
      bcc_op_branch_always:               next_take = 1'b1;
      default:                            next_take = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      take <= 1'b0;
    end else begin
      take <= next_take;
    end
  end
endmodule
`default_nettype wire

// *** design/bcc_branch_call_unit.sv ***
// branch and call control: pc/bank update, stack pushes, operand reads
`timescale 1ns/100ps
`default_nettype none
module bcc_branch_call_unit
  import bcc_pkg::*;
#(
  parameter int CORR_WIDTH = 5
) (
  input  wire logic                  mclk,       // machine clock 25 MHz
  input  wire logic                  arst_n,     // async reset, active low
  input  wire logic                  start,      // instruction issue pulse
  input  wire bcc_op_e               op,         // decoded opcode
  input  wire logic [4:0]            flags,      // {t,n,z,v,c}
  input  wire logic [7:0]            rel,        // signed displacement
  input  wire logic [23:0]           imm,        // immediate address
  input  wire logic [3:0]            vector,     // vector number
  input  wire logic [31:0]           acc,        // accumulator
  input  wire logic [31:0]           operand,    // register operand value
  input  wire logic [15:0]           ea,         // memory operand address
  input  wire logic [CORR_WIDTH-1:0] corr,       // addressing correction
  input  wire logic [15:0]           pc,         // current pc
  input  wire logic [7:0]            bank,       // current code bank
  input  wire logic [31:0]           rd_data,    // read data from memory
  input  wire logic                  rd_ack,     // read data valid
  output logic                       busy,       // instruction in flight
  output logic                       done,       // one-cycle completion
  output logic [15:0]                new_pc,     // next pc
  output logic [7:0]                 new_bank,   // next code bank
  output logic                       bank_we,    // bank written
  output logic                       push_req,   // stack push strobe
  output logic                       push_long,  // push is 32-bit
  output logic [31:0]                push_data,  // return address
  output logic                       rd_req,     // operand read strobe
  output logic                       rd_long,    // read is 32-bit
  output logic [15:0]                rd_addr,    // operand read address
  output logic                       flags_we    // flag write, always low
);
  if (CORR_WIDTH < 1 || CORR_WIDTH > 8) begin : g_corr_width_check
    $error("corr width out of range");
  end

  typedef enum {st_idle, st_eval, st_push, st_read, st_wait, st_count}
    bcc_state_e;

  bcc_state_e state;
  logic       rst_s1, rst_s2;
  logic       take;
  bcc_op_e    cur;
  logic [7:0] cycles;
  logic [7:0] left;
  logic [2:0] len;
  logic [15:0] ret_pc;
  logic        is_branch, need_push, push_l, need_read, read_l;

  // reset released through two flops
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_s2 <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_s2 <= rst_s1;
    end
  end

  bcc_cond_eval u_cond (
    .mclk  (mclk),
    .rst_n (rst_s2),
    .op    (op),
    .flags (flags),
    .take  (take)
  );

  always_comb begin
    is_branch = (cur >= bcc_op_branch_if_zero_set) &&
                (cur <= bcc_op_branch_always);
    need_push = (cur >= bcc_op_call_reg);
    push_l    = (cur >= bcc_op_far_subroutine_invoke_reg);
    need_read = (cur == bcc_op_near_jump_mem) ||
                (cur == bcc_op_far_jump_mem) ||
                (cur == bcc_op_call_mem) ||
                (cur == bcc_op_far_subroutine_invoke_mem);
    read_l    = (cur == bcc_op_far_jump_mem) ||
                (cur == bcc_op_far_subroutine_invoke_mem);
    ret_pc    = pc + 16'(len);
  end

  // per-op cycle budget and length, captured at issue
  always_ff @(posedge mclk or negedge rst_s2) begin
    if (!rst_s2) begin
      cur    <= bcc_op_nop;
      cycles <= 8'h00;
      len    <= BCC_LEN_ONE;
    end else if (start && state == st_idle) begin
      cur <= op;
      case (op)
        bcc_op_near_jump_acc: cycles <= 8'(BCC_CYC_JMP_ACC);
        bcc_op_near_jump_imm: cycles <= 8'(BCC_CYC_JMP_IMM);
        bcc_op_near_jump_reg: cycles <= 8'(BCC_CYC_JMP_REG);
        bcc_op_near_jump_mem:
          cycles <= 8'(BCC_CYC_JMP_MEM) + 8'(corr);
        bcc_op_far_jump_reg:  cycles <= 8'(BCC_CYC_FJMP_REG);
        bcc_op_far_jump_mem:
          cycles <= 8'(BCC_CYC_FJMP_MEM) + 8'(corr);
        bcc_op_far_jump_imm:  cycles <= 8'(BCC_CYC_FJMP_IMM);
        bcc_op_call_reg:      cycles <= 8'(BCC_CYC_CALL_REG);
        bcc_op_call_mem:
          cycles <= 8'(BCC_CYC_CALL_MEM) + 8'(corr);
        bcc_op_call_imm:      cycles <= 8'(BCC_CYC_CALL_IMM);
        bcc_op_vector_subroutine_invoke:
          cycles <= 8'(BCC_CYC_VECTOR_SUBROUTINE_INVOKE);
        bcc_op_far_subroutine_invoke_reg:
          cycles <= 8'(BCC_CYC_FCALL_RG);
        bcc_op_far_subroutine_invoke_mem:
          cycles <= 8'(BCC_CYC_FCALL_MM) + 8'(corr);
        bcc_op_far_subroutine_invoke_imm:
          cycles <= 8'(BCC_CYC_FCALL_IM);
        default: cycles <= 8'(BCC_CYC_BR_NOT);
      endcase
      // return address offset; register and memory forms are two bytes
      case (op)
        bcc_op_near_jump_acc, bcc_op_vector_subroutine_invoke:
          len <= BCC_LEN_ONE;
        bcc_op_near_jump_imm, bcc_op_call_imm:
          len <= BCC_LEN_THREE;
        bcc_op_far_jump_imm, bcc_op_far_subroutine_invoke_imm:
          len <= BCC_LEN_FOUR;
        default: len <= BCC_LEN_BRANCH;
      endcase
    end
  end

  // sequencer: issue, evaluate, push, read, then pad to the cycle budget
  always_ff @(posedge mclk or negedge rst_s2) begin
    if (!rst_s2) begin
      state <= st_idle;
      left  <= 8'h00;
    end else begin
      case (state)
        st_idle: if (start) begin
          state <= st_eval;
        end
        st_eval: begin
          if (is_branch) begin
            // first cycle is issue; eval is second
            left  <= take ? 8'(BCC_CYC_BR_TAKEN - BCC_CYC_BR_NOT) : 8'h00;
            state <= take ? st_count : st_idle;
          end else begin
            left  <= cycles - 8'(BCC_CYC_BR_NOT);
            state <= need_push ? st_push :
                     need_read ? st_read :
                     (cycles <= 8'(BCC_CYC_BR_NOT)) ? st_idle : st_count;
          end
        end
        st_push: begin
          left  <= left - 8'h01;
          state <= need_read ? st_read : st_count;
        end
        st_read: begin
          left  <= left - 8'h01;
          state <= st_wait;
        end
        st_wait: if (rd_ack) begin
          state <= st_count;
        end
        st_count: begin
          if (left <= 8'h01) begin
            state <= st_idle;
          end else begin
            left <= left - 8'h01;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_s2) begin
    if (!rst_s2) begin
      push_req  <= 1'b0;
      push_long <= 1'b0;
      push_data <= 32'h0;
      rd_req    <= 1'b0;
      rd_long   <= 1'b0;
      rd_addr   <= 16'h0;
    end else begin
      push_req <= (state == st_eval) && !is_branch && need_push;
      if ((state == st_eval) && need_push) begin
        push_long <= push_l;
        push_data <= push_l ? {8'h00, bank, ret_pc} : {16'h0, ret_pc};
      end
      rd_req <= ((state == st_eval) && !is_branch && need_read &&
                 !need_push) || (state == st_push && need_read);
      if (state == st_eval) begin
        rd_long <= read_l;
        rd_addr <= ea;
      end
    end
  end

  // pc/bank result; flags never written by this group
  always_ff @(posedge mclk or negedge rst_s2) begin
    if (!rst_s2) begin
      busy     <= 1'b0;
      done     <= 1'b0;
      new_pc   <= 16'h0;
      new_bank <= 8'h00;
      bank_we  <= 1'b0;
      flags_we <= 1'b0;
    end else begin
      busy    <= (state != st_idle) || start;
      done    <= 1'b0;
      bank_we <= 1'b0;
      flags_we <= 1'b0;
      if (state == st_eval && is_branch) begin
        new_pc <= take ? ret_pc + {{8{rel[7]}}, rel} : ret_pc;
        new_bank <= bank;
        done <= !take;
      end else if (state == st_wait && rd_ack) begin
        new_pc <= rd_data[BCC_PC_MSB:BCC_PC_LSB];
        new_bank <= rd_long ? rd_data[BCC_BANK_MSB:BCC_BANK_LSB] : bank;
        bank_we <= rd_long;
      end else if (state == st_eval) begin
        new_bank <= bank;
        // two-cycle forms have no padding left and finish here
        done     <= (cycles <= 8'(BCC_CYC_BR_NOT)) && !need_push &&
                    !need_read;
        case (cur)
          bcc_op_near_jump_acc: new_pc <= acc[BCC_PC_MSB:BCC_PC_LSB];
          bcc_op_near_jump_imm,
          bcc_op_call_imm:      new_pc <= imm[BCC_PC_MSB:BCC_PC_LSB];
          bcc_op_vector_subroutine_invoke:
            new_pc <= BCC_VEC_BASE + ({12'h0, vector} << BCC_VEC_SHIFT);
          bcc_op_far_jump_imm, bcc_op_far_subroutine_invoke_imm: begin
            new_pc   <= imm[BCC_PC_MSB:BCC_PC_LSB];
            new_bank <= imm[BCC_BANK_MSB:BCC_BANK_LSB];
            bank_we  <= 1'b1;
          end
          bcc_op_far_jump_reg, bcc_op_far_subroutine_invoke_reg: begin
            new_pc   <= operand[BCC_PC_MSB:BCC_PC_LSB];
            new_bank <= operand[BCC_BANK_MSB:BCC_BANK_LSB];
            bank_we  <= 1'b1;
          end
          bcc_op_near_jump_reg, bcc_op_call_reg:
            new_pc <= operand[BCC_PC_MSB:BCC_PC_LSB];
          default: new_pc <= new_pc;
        endcase
      end
      if (state == st_count && left <= 8'h01)
        done <= 1'b1;
    end
  end

  sequence s_taken;
    (state == st_eval) && is_branch && take;
  endsequence

  AST_TAKEN_THREE: assert property (@(posedge mclk) disable iff (!rst_s2)
    s_taken |=> ##1 done) else $error("taken branch not 3 cycles");
  AST_NOT_TAKEN_TWO: assert property (@(posedge mclk) disable iff (!rst_s2)
    (state == st_eval) && is_branch && !take |=> done)
    else $error("fallthrough not 2 cycles");
  AST_NO_FLAGS: assert property (@(posedge mclk) disable iff (!rst_s2)
    !flags_we) else $error("flags written");
  AST_ACC_JUMP: assert property (@(posedge mclk) disable iff (!rst_s2)
    (state == st_eval) && cur == bcc_op_near_jump_acc
    |=> new_pc == $past(acc[15:0]) && !bank_we && done)
    else $error("acc jump wrong");
  AST_FAR_IMM: assert property (@(posedge mclk) disable iff (!rst_s2)
    (state == st_eval) && cur == bcc_op_far_jump_imm
    |=> bank_we && new_bank == $past(imm[23:16]))
    else $error("far jump bank wrong");
  AST_FCALL_PUSH: assert property (@(posedge mclk) disable iff (!rst_s2)
    push_req && $past(cur) >= bcc_op_far_subroutine_invoke_reg |-> push_long)
    else $error("far call push not long");
  AST_NEAR_PUSH: assert property (@(posedge mclk) disable iff (!rst_s2)
    push_req && cur < bcc_op_far_subroutine_invoke_reg |-> !push_long)
    else $error("near call push not word");
  AST_PUSH_BEFORE_READ: assert property (@(posedge mclk)
    disable iff (!rst_s2)
    push_req && need_read |=> rd_req)
    else $error("read not after push");
endmodule
`default_nettype wire

// *** tb/bcc_branch_call_unit_tb.sv ***
// self-checking testbench for the branch and call control unit
`timescale 1ns/100ps
`default_nettype none
module bcc_branch_call_unit_tb
  import bcc_pkg::*;
;
  logic        mclk = 1'b0;
  logic        arst_n = 1'b0;
  logic        start = 1'b0;
  bcc_op_e     op = bcc_op_nop;
  logic [4:0]  flags = 5'h00;
  logic [7:0]  rel = 8'h00;
  logic [23:0] imm = 24'h000000;
  logic [3:0]  vector = 4'h0;
  logic [31:0] acc = 32'h00000000;
  logic [31:0] operand = 32'h00000000;
  logic [15:0] ea = 16'h0000;
  logic [4:0]  corr = 5'h00;
  logic [15:0] pc = 16'h0000;
  logic [7:0]  bank = 8'h00;
  logic [31:0] rd_data = 32'h00000000;
  logic        rd_ack = 1'b0;
  logic        busy, done, bank_we, push_req, push_long, rd_req, rd_long;
  logic        flags_we;
  logic [15:0] new_pc, rd_addr;
  logic [7:0]  new_bank;
  logic [31:0] push_data;
  int          n_errors = 0;
  int          comparisons = 0;
  int          n_push, n_bwe, n_rd;
  logic        in_op = 1'b0;
  logic        ack_pend = 1'b0;
  logic [31:0] rd_word = 32'h00000000;
  logic [31:0] seen_push;
  logic        seen_plong, seen_rlong;
  logic [15:0] seen_raddr;

  bcc_branch_call_unit #(.CORR_WIDTH(5)) u_dut (
    .mclk(mclk), .arst_n(arst_n), .start(start), .op(op), .flags(flags),
    .rel(rel), .imm(imm), .vector(vector), .acc(acc), .operand(operand),
    .ea(ea), .corr(corr), .pc(pc), .bank(bank), .rd_data(rd_data),
    .rd_ack(rd_ack), .busy(busy), .done(done), .new_pc(new_pc),
    .new_bank(new_bank), .bank_we(bank_we), .push_req(push_req),
    .push_long(push_long), .push_data(push_data), .rd_req(rd_req),
    .rd_long(rd_long), .rd_addr(rd_addr), .flags_we(flags_we)
  );

  always #20 mclk = ~mclk;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task tally_and_finish;
    if (n_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // memory answers one cycle after the read strobe; the bus then drifts
  always @(negedge mclk) begin
    if (ack_pend) begin
      rd_ack = 1'b1;
      rd_data = rd_word;
      ack_pend = 1'b0;
    end else begin
      if (rd_ack)
        rd_data = ~rd_data;
      rd_ack = 1'b0;
      if (rd_req === 1'b1) begin
        ack_pend = 1'b1;
        seen_raddr = rd_addr;
        seen_rlong = rd_long;
        n_rd++;
      end
    end
    if (push_req === 1'b1) begin
      seen_push = push_data;
      seen_plong = push_long;
      n_push++;
    end
    if (bank_we === 1'b1)
      n_bwe++;
    if (in_op)
      check("flags_we", flags_we, 32'h0);
  end

  task automatic run_op(input bcc_op_e o, input logic [15:0] epc,
                        input logic [7:0] ebank, input logic bwe,
                        input int npush, input logic [31:0] epush,
                        input logic elong, input int cmin, input int cmax);
    int cyc;
    int nrd;
    @(negedge mclk);
    n_push = 0;
    n_bwe = 0;
    n_rd = 0;
    nrd = (o == bcc_op_near_jump_mem || o == bcc_op_far_jump_mem ||
           o == bcc_op_call_mem ||
           o == bcc_op_far_subroutine_invoke_mem) ? 1 : 0;
    in_op = 1'b1;
    op = o;
    start = 1'b1;
    @(negedge mclk);
    start = 1'b0;
    check("busy at issue", 32'(busy), 32'h1);
    // the issue cycle is cycle 0, so this is already cycle 1
    cyc = 1;
    while (done !== 1'b1 && cyc < 40) begin
      @(negedge mclk);
      cyc++;
    end
    in_op = 1'b0;
    check("cycles in range", 32'(cyc >= cmin && cyc <= cmax), 32'h1);
    check("new_pc", 32'(new_pc), 32'(epc));
    check("bank_we pulses", n_bwe, 32'(bwe));
    if (bwe)
      check("new_bank", 32'(new_bank), 32'(ebank));
    check("push count", n_push, npush);
    check("read count", n_rd, nrd);
    if (npush > 0) begin
      check("push_data", seen_push, epush);
      check("push_long", 32'(seen_plong), 32'(elong));
    end
  endtask

  function automatic logic want_take(input bcc_op_e o, input logic [4:0] f);
    logic c, v, z, n, t;
    {t, n, z, v, c} = f;
    case (o)
      bcc_op_branch_if_zero_set:          return z;
      bcc_op_branch_if_zero_clear:        return !z;
      bcc_op_branch_if_carry_set:         return c;
      bcc_op_branch_if_carry_clear:       return !c;
      bcc_op_branch_if_negative:          return n;
      bcc_op_branch_if_positive:          return !n;
      bcc_op_branch_if_overflow:          return v;
      bcc_op_branch_if_no_overflow:       return !v;
      bcc_op_branch_if_sticky:            return t;
      bcc_op_branch_if_not_sticky:        return !t;
      bcc_op_branch_signed_less:          return v ^ n;
      bcc_op_branch_signed_greater_equal: return !(v ^ n);
      bcc_op_branch_signed_less_equal:    return (v ^ n) | z;
      bcc_op_branch_signed_greater:       return !((v ^ n) | z);
      bcc_op_branch_unsigned_lower_same:  return c | z;
      bcc_op_branch_unsigned_higher:      return !(c | z);
      default:                            return 1'b1;
    endcase
  endfunction

  // every condition against every flag pattern, both displacement signs
  task automatic test_branches;
    bcc_op_e o;
    logic    tk;
    logic [15:0] epc;
    for (int i = 1; i <= 17; i++) begin
      for (int f = 0; f < 32; f++) begin
        o = bcc_op_e'(i);
        flags = 5'(f);
        rel = f[0] ? 8'h80 : 8'h7f;
        pc = 16'h8000 + 16'(f * 7);
        tk = want_take(o, 5'(f));
        epc = tk ? pc + 16'h0002 + {{8{rel[7]}}, rel} : pc + 16'h0002;
        run_op(o, epc, 8'h00, 1'b0, 0, 32'h0, 1'b0, tk ? 3 : 2, tk ? 3 : 2);
      end
    end
  endtask

  task automatic test_jumps;
    pc = 16'h4321;
    bank = 8'h5a;
    acc = 32'hdead_beef;
    run_op(bcc_op_near_jump_acc, 16'hbeef, 8'h00, 1'b0, 0, 32'h0, 1'b0,
           2, 2);
    imm = 24'h3c_9876;
    run_op(bcc_op_far_jump_imm, 16'h9876, 8'h3c, 1'b1, 0, 32'h0, 1'b0,
           3, 3);
    operand = 32'h0081_2468;
    run_op(bcc_op_far_jump_reg, 16'h2468, 8'h81, 1'b1, 0, 32'h0, 1'b0,
           3, 3);
    ea = 16'h0a50;
    rd_word = 32'h00e7_1357;
    run_op(bcc_op_far_jump_mem, 16'h1357, 8'he7, 1'b1, 0, 32'h0, 1'b0,
           4, 10);
    check("far jump read address", 32'(seen_raddr), 32'h0a50);
    run_op(bcc_op_near_jump_imm, 16'h9876, 8'h00, 1'b0, 0, 32'h0, 1'b0,
           2, 2);
    run_op(bcc_op_near_jump_reg, 16'h2468, 8'h00, 1'b0, 0, 32'h0, 1'b0,
           3, 3);
    run_op(bcc_op_near_jump_mem, 16'h1357, 8'h00, 1'b0, 0, 32'h0, 1'b0,
           4, 10);
  endtask

  task automatic test_near_calls;
    pc = 16'hfffe;
    bank = 8'h12;
    imm = 24'h00_2000;
    run_op(bcc_op_call_imm, 16'h2000, 8'h00, 1'b0, 1, 32'h0000_0001,
           1'b0, 5, 5);
    for (int k = 0; k < 16; k += 15) begin
      vector = 4'(k);
      pc = 16'h0100;
      run_op(bcc_op_vector_subroutine_invoke, 16'hffc0 + 16'(k * 2),
             8'h00, 1'b0, 1, 32'h0000_0101, 1'b0, 5, 5);
    end
    operand = 32'h5555_4444;
    run_op(bcc_op_call_reg, 16'h4444, 8'h00, 1'b0, 1, 32'h0000_0102,
           1'b0, 4, 4);
    ea = 16'h7ffe;
    rd_word = 32'h0000_abcd;
    run_op(bcc_op_call_mem, 16'habcd, 8'h00, 1'b0, 1, 32'h0000_0102,
           1'b0, 5, 11);
    check("near call read address", 32'(seen_raddr), 32'h7ffe);
    check("near call read is word", 32'(seen_rlong), 32'h0);
  endtask

  task automatic test_far_calls;
    pc = 16'h3000;
    bank = 8'hc4;
    imm = 24'h7f_0010;
    run_op(bcc_op_far_subroutine_invoke_imm, 16'h0010, 8'h7f, 1'b1, 1,
           32'h00c4_3004, 1'b1, 7, 7);
    operand = 32'hff01_8000;
    run_op(bcc_op_far_subroutine_invoke_reg, 16'h8000, 8'h01, 1'b1, 1,
           32'h00c4_3002, 1'b1, 7, 7);
    ea = 16'h0200;
    corr = 5'h03;
    rd_word = 32'h0099_0ff0;
    run_op(bcc_op_far_subroutine_invoke_mem, 16'h0ff0, 8'h99, 1'b1, 1,
           32'h00c4_3002, 1'b1, 11, 17);
    check("far call read address", 32'(seen_raddr), 32'h0200);
    check("far call read is long", 32'(seen_rlong), 32'h1);
    corr = 5'h00;
  endtask

  initial begin
    #(40 * 20000);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(negedge mclk);
    check("busy in reset", 32'(busy), 32'h0);
    check("done in reset", 32'(done), 32'h0);
    arst_n = 1'b1;
    // synchroniser plus first legal issue edge
    repeat (4) @(negedge mclk);
    test_branches();
    test_jumps();
    test_near_calls();
    test_far_calls();
    tally_and_finish();
  end
endmodule
`default_nettype wire
